// ---- src/bce_top.sv ----
// Purpose: Branch decision for the arithmetic and control unit sequencer
// Assumes: One instruction strobe per executed instruction, same clock
// Notes: Flags loaded by arithmetic through the flag_load strobe and flag_value
`timescale 1ns/1ps

module bce_top
    import bce_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Instruction from sequencer
    input wire logic instr_valid,
    input wire logic instr_is_branch,
    input wire logic long_branch,
    input wire logic [bce_pkg::VW-1:0] first_variant_char,
    input wire logic [bce_pkg::VW-1:0] second_variant_char,
    input wire logic svc_req,
    // Flag updates from arithmetic
    input wire logic flag_load,
    input wire bce_pkg::bce_flags_t flag_value,
    input wire logic overflow,
    // Decision outputs
    output bce_pkg::bce_dec_t decision,
    output logic load_branch_addr,
    output bce_pkg::bce_flags_t flags
);
    logic rst_s1;
    logic rst_n;
    logic met_first;
    logic met_second;
    logic is_long;
    logic second_bad;
    logic first_bad;
    bce_dec_t next_decision;

    // Reset release synchroniser
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // Per-character condition tests
    bce_cond u_first (
        .variant(first_variant_char),
        .flags(flags),
        .svc_req(svc_req),
        .met(met_first)
    );
    bce_cond u_second (
        .variant(second_variant_char),
        .flags(flags),
        .svc_req(svc_req),
        .met(met_second)
    );

    // Legality of the variant pair
    always_comb
    begin
        is_long = long_branch;
        first_bad = !is_long && (first_variant_char == VAR_XFER
            || first_variant_char == VAR_SREQ);
        second_bad = 1'b0;
        if (is_long)
        begin
            if (second_variant_char == VAR_XFER || second_variant_char == VAR_SREQ)
                second_bad = 1'b1;
            if (first_variant_char == VAR_SREQ && second_variant_char != VAR_NOP9
                && second_variant_char != VAR_NOP0)
                second_bad = 1'b1;
            if (second_variant_char > VAR_NOP9)
                second_bad = 1'b1;
        end
        if (first_variant_char > VAR_NOP9)
            first_bad = 1'b1;
    end

    // Branch decision from current flags
    always_comb
    begin
        next_decision = DEC_RST;
        if (instr_valid && instr_is_branch)
        begin
            next_decision.illegal = first_bad || second_bad;
            if (!next_decision.illegal)
            begin
                case (first_variant_char)
                    VAR_XFER:
                    begin
                        next_decision.taken = met_second;
                        next_decision.transfer = met_second;
                    end
                    VAR_SREQ: next_decision.taken = met_first;
                    VAR_SWITCH:
                    begin
                        next_decision.taken = 1'b1;
                        next_decision.part_switch = 1'b1;
                    end
                    default: next_decision.taken = met_first;
                endcase
            end
        end
    end

    // Decision register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            decision <= DEC_RST;
            load_branch_addr <= 1'b0;
        end
        else
        begin
            decision <= next_decision;
            load_branch_addr <= next_decision.taken;
        end
    end

    // Condition flip-flops
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            flags <= FLAGS_RST;
        else if (instr_valid && !instr_is_branch)
            flags <= FLAGS_RST;
        else if (flag_load)
        begin
            flags <= flag_value;
            if (overflow)
            begin
                flags.carry <= 1'b1;
                flags.minus <= 1'b1;
            end
        end
    end

    // Checks
    property p_clear;
        @(posedge clk) disable iff (!rst_n)
        instr_valid && !instr_is_branch |=> flags == FLAGS_RST;
    endproperty
    a_clear: assert property (p_clear) else $error("flags not cleared");

    property p_zero;
        @(posedge clk) disable iff (!rst_n)
        instr_valid && instr_is_branch && !long_branch
        && first_variant_char == VAR_ZERO |=> load_branch_addr == $past(flags.zero);
    endproperty
    a_zero: assert property (p_zero) else $error("variant 2 wrong");

    property p_ovf;
        @(posedge clk) disable iff (!rst_n)
        flag_load && overflow && !(instr_valid && !instr_is_branch)
        |=> flags.minus && flags.carry;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flags wrong");

    property p_sreq;
        @(posedge clk) disable iff (!rst_n)
        instr_valid && instr_is_branch && long_branch && first_variant_char == VAR_SREQ
        && second_variant_char == VAR_NOP9 |=> load_branch_addr == $past(svc_req);
    endproperty
    a_sreq: assert property (p_sreq) else $error("service branch wrong");

    property p_sw;
        @(posedge clk) disable iff (!rst_n)
        instr_valid && instr_is_branch && first_variant_char == VAR_SWITCH
        && (!long_branch || second_variant_char == VAR_NOP0)
        |=> decision.part_switch && load_branch_addr;
    endproperty
    a_sw: assert property (p_sw) else $error("switch branch wrong");

    property p_pos;
        @(posedge clk) disable iff (!rst_n)
        instr_valid && instr_is_branch && !long_branch && first_variant_char == VAR_SREQ
        |=> decision.illegal && !load_branch_addr;
    endproperty
    a_pos: assert property (p_pos) else $error("short variant 7 accepted");

    property p_xfer;
        @(posedge clk) disable iff (!rst_n)
        instr_valid && instr_is_branch && long_branch && first_variant_char == VAR_XFER
        && second_variant_char == VAR_CARRY |=> decision.transfer == $past(flags.carry);
    endproperty
    a_xfer: assert property (p_xfer) else $error("transfer condition wrong");

    property p_sreq2;
        @(posedge clk) disable iff (!rst_n)
        instr_valid && instr_is_branch && long_branch && first_variant_char == VAR_SREQ
        && second_variant_char != VAR_NOP9 && second_variant_char != VAR_NOP0
        |=> decision.illegal && !load_branch_addr;
    endproperty
    a_sreq2: assert property (p_sreq2) else $error("bad pair accepted");

    property p_nop;
        @(posedge clk) disable iff (!rst_n)
        instr_valid && instr_is_branch && !long_branch
        && (first_variant_char == VAR_NOP9 || first_variant_char == VAR_NOP0)
        |=> decision == DEC_RST && !load_branch_addr;
    endproperty
    a_nop: assert property (p_nop) else $error("nop branched");

    property p_load;
        @(posedge clk) disable iff (!rst_n)
        load_branch_addr |-> $past(instr_valid && instr_is_branch);
    endproperty
    a_load: assert property (p_load) else $error("stray address load");
endmodule

// ---- src/bce_pkg.sv ----
// Purpose: Shared constants and carriers for the branch condition evaluator
// Assumes: Variant characters are 4-bit decimal digits 0..9
// Notes: Flag bundle and decision bundle travel as packed structs
package bce_pkg;
    localparam int VW = 4;
    localparam logic [3:0] VAR_NOP0 = 4'h0;
    localparam logic [3:0] VAR_MINUS = 4'h1;
    localparam logic [3:0] VAR_ZERO = 4'h2;
    localparam logic [3:0] VAR_PLUS = 4'h3;
    localparam logic [3:0] VAR_CARRY = 4'h4;
    localparam logic [3:0] VAR_UNCOND = 4'h5;
    localparam logic [3:0] VAR_XFER = 4'h6;
    localparam logic [3:0] VAR_SREQ = 4'h7;
    localparam logic [3:0] VAR_SWITCH = 4'h8;
    localparam logic [3:0] VAR_NOP9 = 4'h9;
    localparam logic RST_FLAG = 1'b0;

    // Condition flip-flops
    typedef struct packed {
        logic zero;
        logic minus;
        logic carry;
    } bce_flags_t;

    // Result of one branch evaluation
    typedef struct packed {
        logic taken;
        logic transfer;
        logic part_switch;
        logic illegal;
    } bce_dec_t;

    localparam bce_flags_t FLAGS_RST = '{zero: RST_FLAG, minus: RST_FLAG, carry: RST_FLAG};
    localparam bce_dec_t DEC_RST = '{taken: 1'b0, transfer: 1'b0, part_switch: 1'b0,
        illegal: 1'b0};
endpackage

// ---- src/bce_cond.sv ----
// Purpose: Tests one variant character against the condition flags
// Assumes: Pure combinational, flags sampled by the caller
// Notes: Instantiated once per variant character
`timescale 1ns/1ps
module bce_cond
    import bce_pkg::*;
(
    // Inputs
    input wire logic [bce_pkg::VW-1:0] variant,
    input wire bce_pkg::bce_flags_t flags,
    input wire logic svc_req,
    // Result
    output logic met
);
    // Variant condition table
    always_comb
    begin
        case (variant)
            VAR_MINUS: met = !flags.zero && flags.minus;
            VAR_ZERO: met = flags.zero;
            VAR_PLUS: met = !flags.zero && !flags.minus;
            VAR_CARRY: met = flags.carry;
            VAR_UNCOND: met = 1'b1;
            VAR_SREQ: met = svc_req;
            VAR_SWITCH: met = 1'b1;
            default: met = 1'b0;
        endcase
    end
endmodule

// ---- verif/bce_seq_model.sv ----
// Purpose: Sequencer model that issues instructions and flag updates
// Assumes: Drives just after the falling edge, one request every second cycle
// Notes: Variant pairs are chosen by the caller, illegal ones on purpose only
`timescale 1ns/1ps
module bce_seq_model
    import bce_pkg::*;
(
    // Clock
    input wire logic clk,
    // Instruction and flag drive
    output logic instr_valid,
    output logic instr_is_branch,
    output logic long_branch,
    output logic [bce_pkg::VW-1:0] first_variant_char,
    output logic [bce_pkg::VW-1:0] second_variant_char,
    output logic svc_req,
    output logic flag_load,
    output bce_pkg::bce_flags_t flag_value,
    output logic overflow
);
    // Idle levels at time zero
    initial
    begin
        {instr_valid, instr_is_branch, long_branch, svc_req, flag_load, overflow} = 6'h00;
        {first_variant_char, second_variant_char, flag_value} = 11'h000;
    end

    // One request for one cycle, then idle with scrambled data lines
    task automatic cycle(input logic iv, input logic br, input logic lng, input logic [3:0] a,
        input logic [3:0] b, input logic sv, input logic fl, input bce_flags_t fv, input logic ov);
        @(negedge clk);
        {instr_valid, instr_is_branch, long_branch, svc_req} = {iv, br, lng, sv};
        {first_variant_char, second_variant_char} = {a, b};
        {flag_load, flag_value, overflow} = {fl, fv, ov};
        @(negedge clk);
        {instr_valid, flag_load, overflow} = 3'h0;
        {first_variant_char, second_variant_char, flag_value} = ~{a, b, fv};
    endtask
endmodule

// ---- verif/branch_condition_evaluator_bench.sv ----
// Purpose: Self-checking bench for the branch decision block
// Assumes: Decision appears at the edge that takes the instruction
// Notes: Flags order is zero, minus, carry from high bit down
`timescale 1ns/1ps
module branch_condition_evaluator_bench;
    import bce_pkg::*;
    logic clk, nrst, instr_valid, instr_is_branch, long_branch, svc_req, flag_load, overflow;
    logic load_branch_addr;
    logic [3:0] first_variant_char, second_variant_char;
    bce_flags_t flag_value, flags;
    bce_dec_t decision;
    int fails, checks_done;

    // Design and sequencer model
    bce_top dut_u (.clk(clk), .nrst(nrst), .instr_valid(instr_valid),
        .instr_is_branch(instr_is_branch), .long_branch(long_branch),
        .first_variant_char(first_variant_char), .second_variant_char(second_variant_char),
        .svc_req(svc_req), .flag_load(flag_load), .flag_value(flag_value),
        .overflow(overflow), .decision(decision), .load_branch_addr(load_branch_addr),
        .flags(flags));
    bce_seq_model seq_u (.clk(clk), .instr_valid(instr_valid),
        .instr_is_branch(instr_is_branch), .long_branch(long_branch),
        .first_variant_char(first_variant_char), .second_variant_char(second_variant_char),
        .svc_req(svc_req), .flag_load(flag_load), .flag_value(flag_value),
        .overflow(overflow));

    // 250 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Branch, then decision bits taken, transfer, switch, illegal
    task automatic br(input logic lng, input logic [3:0] a, input logic [3:0] b,
        input logic sv, input logic [3:0] exp);
        seq_u.cycle(1'b1, 1'b1, lng, a, b, sv, 1'b0, FLAGS_RST, 1'b0);
        chk("decision", exp, decision);
        chk("load_branch_addr", {3'h0, exp[3]}, {3'h0, load_branch_addr});
    endtask

    task automatic ld(input logic [2:0] v, input logic ov, input logic [2:0] exp);
        seq_u.cycle(1'b0, 1'b0, 1'b0, 4'h0, 4'h0, 1'b0, 1'b1, v, ov);
        chk("flags", {1'b0, exp}, {1'b0, flags});
    endtask

    task automatic test_done;
        if (fails == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        #4000;
        fails++;
        test_done();
    end

    // Test sequence
    initial
    begin
        fails = 0;
        checks_done = 0;
        nrst = 1'b0;
        repeat (8) @(negedge clk);
        chk("flags", 4'h0, {1'b0, flags});
        chk("decision", 4'h0, decision);
        nrst = 1'b1;
        repeat (2) @(negedge clk);
        ld(3'h4, 1'b0, 3'h4);
        br(1'b0, 4'h2, 4'h0, 1'b0, 4'h8);
        br(1'b0, 4'h1, 4'h0, 1'b0, 4'h0);
        br(1'b0, 4'h3, 4'h0, 1'b0, 4'h0);
        br(1'b0, 4'h4, 4'h0, 1'b0, 4'h0);
        br(1'b0, 4'h5, 4'h0, 1'b0, 4'h8);
        br(1'b0, 4'h9, 4'h0, 1'b0, 4'h0);
        br(1'b0, 4'h0, 4'h0, 1'b0, 4'h0);
        br(1'b0, 4'h8, 4'h0, 1'b0, 4'hA);
        chk("flags", 4'h4, {1'b0, flags});
        ld(3'h2, 1'b0, 3'h2);
        br(1'b0, 4'h1, 4'h0, 1'b0, 4'h8);
        br(1'b0, 4'h3, 4'h0, 1'b0, 4'h0);
        br(1'b0, 4'h2, 4'h0, 1'b0, 4'h0);
        ld(3'h1, 1'b0, 3'h1);
        br(1'b0, 4'h3, 4'h0, 1'b0, 4'h8);
        br(1'b0, 4'h4, 4'h0, 1'b0, 4'h8);
        ld(3'h0, 1'b1, 3'h3);
        br(1'b0, 4'h4, 4'h0, 1'b0, 4'h8);
        br(1'b1, 4'h6, 4'h1, 1'b0, 4'hC);
        br(1'b1, 4'h6, 4'h2, 1'b0, 4'h0);
        br(1'b1, 4'h6, 4'h3, 1'b0, 4'h0);
        br(1'b1, 4'h6, 4'h4, 1'b0, 4'hC);
        br(1'b1, 4'h6, 4'h5, 1'b0, 4'hC);
        br(1'b1, 4'h6, 4'h9, 1'b0, 4'h0);
        br(1'b1, 4'h7, 4'h9, 1'b1, 4'h8);
        br(1'b1, 4'h7, 4'h0, 1'b0, 4'h0);
        br(1'b1, 4'h7, 4'h0, 1'b1, 4'h8);
        br(1'b1, 4'h8, 4'h0, 1'b0, 4'hA);
        br(1'b1, 4'h4, 4'h9, 1'b0, 4'h8);
        br(1'b1, 4'h6, 4'h0, 1'b0, 4'h0);
        br(1'b0, 4'h6, 4'h0, 1'b0, 4'h1);
        br(1'b0, 4'h7, 4'h0, 1'b1, 4'h1);
        br(1'b1, 4'h2, 4'h6, 1'b0, 4'h1);
        br(1'b1, 4'h5, 4'h7, 1'b0, 4'h1);
        br(1'b1, 4'h7, 4'h3, 1'b1, 4'h1);
        br(1'b0, 4'hA, 4'h0, 1'b0, 4'h1);
        seq_u.cycle(1'b1, 1'b0, 1'b0, 4'h2, 4'h0, 1'b0, 1'b0, 3'h0, 1'b0);
        chk("flags", 4'h0, {1'b0, flags});
        chk("decision", 4'h0, decision);
        ld(3'h7, 1'b0, 3'h7);
        seq_u.cycle(1'b1, 1'b0, 1'b0, 4'h5, 4'h0, 1'b0, 1'b1, 3'h7, 1'b0);
        chk("flags", 4'h0, {1'b0, flags});
        seq_u.cycle(1'b1, 1'b1, 1'b0, 4'h2, 4'h0, 1'b0, 1'b1, 3'h4, 1'b0);
        chk("decision", 4'h0, decision);
        chk("flags", 4'h4, {1'b0, flags});
        br(1'b0, 4'h2, 4'h0, 1'b0, 4'h8);
        // Mid-run reset clears loaded flags
        ld(3'h7, 1'b0, 3'h7);
        nrst = 1'b0;
        @(negedge clk);
        chk("flags", 4'h0, {1'b0, flags});
        nrst = 1'b1;
        repeat (2) @(negedge clk);
        br(1'b0, 4'h2, 4'h0, 1'b0, 4'h0);
        test_done();
    end
endmodule
